//--- phci_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the host
  command issuer. Assumes inclusion by bare name from its users.
*/
`ifndef PHCI_DEFINES_SVH
`define PHCI_DEFINES_SVH

// Register byte offsets
`define PHCI_OFS_CTRL      12'h0000
`define PHCI_OFS_STATUS    12'h0004
`define PHCI_OFS_IRQ_STAT  12'h0008
`define PHCI_OFS_IRQ_MASK  12'h000C
`define PHCI_OFS_COUNTS    12'h0010
`define PHCI_OFS_ROUTE     12'h0014
`define PHCI_OFS_RETRY     12'h0018
`define PHCI_OFS_RSP_LEN   12'h001C
// Windows: address bits 11:10 select command or response buffer
`define PHCI_WIN_CMD       2'h1
`define PHCI_WIN_RSP       2'h2

// CTRL fields
`define PHCI_CTRL_START    0
`define PHCI_CTRL_FULLDPX  1
`define PHCI_CTRL_SMALLNET 2
// IRQ fields
`define PHCI_IRQ_DONE      0
`define PHCI_IRQ_TIMEOUT   1
`define PHCI_IRQ_DISCARD   2
`define PHCI_IRQ_PARAM     3
`define PHCI_IRQ_W         4

// Reset values
`define PHCI_CTRL_RST      3'h2
`define PHCI_COUNTS_RST    32'h0002_0002
`define PHCI_ROUTE_RST     32'h0010_0000
`define PHCI_RETRY_RST     32'h0000_0000

// Limits of the control data
`define PHCI_BUF_BYTES     544
`define PHCI_CNT_MIN       10'h002
`define PHCI_CNT_MAX       10'h21E
`define PHCI_NET_MAX       8'h7F
`define PHCI_NODE_MAX_BIG  8'h7E
`define PHCI_NODE_MAX_SML  8'h3E
`define PHCI_UNIT_MIN      8'h10
`define PHCI_UNIT_MAX      8'h1F

// Timing
`define PHCI_CLK_NS        4
`define PHCI_TICK_NS       100000000
`define PHCI_MON_DEFAULT   16'h0014

`endif

//--- phci_host_model.sv
/*
  Host side of the link: takes command bytes, stalls on request, and
  returns a reply of the asked length. Assumes the bench sets reply_len
  and pat before a command starts.
*/
`timescale 1ns/1ps
module phci_host_model (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [7:0] cmd_tx_data,
  input  wire logic       cmd_tx_valid,
  input  wire logic       cmd_tx_last,
  output logic            cmd_tx_ready,
  output logic      [7:0] rsp_rx_data,
  output logic            rsp_rx_valid,
  output logic            rsp_rx_last,
  input  wire logic       slow,
  input  wire logic [31:0] reply_len,
  input  wire logic [7:0] pat,
  output int              n_got,
  output logic      [7:0] last_got
);
  int   left_r;
  logic stall_r;

  assign cmd_tx_ready = !stall_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stall_r      <= 1'b0;
      n_got        <= 0;
      last_got     <= 8'h00;
      left_r       <= 0;
      rsp_rx_valid <= 1'b0;
      rsp_rx_last  <= 1'b0;
      rsp_rx_data  <= 8'h00;
    end else begin
      stall_r      <= slow && !stall_r;
      rsp_rx_valid <= 1'b0;
      rsp_rx_last  <= 1'b0;
      // Idle data line toggles each cycle instead of holding the last byte
      rsp_rx_data  <= ~rsp_rx_data;
      if (cmd_tx_valid && cmd_tx_ready) begin
        n_got    <= n_got + 1;
        last_got <= cmd_tx_data;
        // Three idle cycles before a reply; zero length means a silent host
        if (cmd_tx_last && reply_len > 0) begin
          left_r <= reply_len + 3;
        end
      end else if (left_r > 0) begin
        left_r <= left_r - 1;
        if (left_r <= reply_len) begin
          rsp_rx_valid <= 1'b1;
          rsp_rx_last  <= (left_r == 1);
          rsp_rx_data  <= 8'(reply_len - left_r) ^ pat;
        end
      end
    end
  end
endmodule // phci_host_model

//--- phci_issuer.sv
/*
  Host command issuer: APB register file, command and response buffers,
  command sender with retries and response monitor, duplex ordering.
  Assumes a byte-wide link framer outside: it takes command bytes, hands
  response bytes back, and reports the state of host commands and replies.
*/
`timescale 1ns/1ps
`include "phci_defines.svh"

// Behaviour
// (RULE_01) Software sets transmit byte count 0002 to 021E including command code.
// (RULE_02) Software sets receive byte count to expected reply length, at most 542.
// (RULE_03) Reply longer than receive count is discarded, destination left untouched.
// (RULE_04) Shorter reply is stored; bytes beyond it stay unchanged.
// (RULE_05) Network field is 00 local, or 01 to 7F remote.
// (RULE_06) Node field 00 local, else 01-7E large net or 01-3E small net.
// (RULE_07) Unit address field must lie within 10 to 1F.
// (RULE_08) Designation bit 0 expects a reply, 1 expects none.
// (RULE_09) Controller port field holds 0 to 7.
// (RULE_10) Unanswered command is resent at most the configured 0 to 15 times.
// (RULE_11) Reply wait is code times 0.1 s; code 0000 means 2 s.
// (RULE_12) Link port field picks one of two serial ports, 0 the first.
// (RULE_13) Send ordering follows the full or half duplex setting.
// (RULE_14) Full duplex: command may start while a host command is arriving.
// (RULE_15) Full duplex: reply to host waits until our command is sent.
// (RULE_16) A reply being sent defers a new command until it ends.
// (RULE_17) Host response delay holds off a new command until it elapses.
// (RULE_18) No-reply command raises execution-possible once handed to the unit.
// (RULE_19) Reply-needed command keeps execution-possible low until reply or give-up.
module phci_issuer #(
  parameter int unsigned TICK_CYCLES = `PHCI_TICK_NS / `PHCI_CLK_NS
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic      [7:0]  cmd_tx_data,
  output logic             cmd_tx_valid,
  output logic             cmd_tx_last,
  input  wire logic        cmd_tx_ready,
  output logic             link_port_sel,
  input  wire logic [7:0]  rsp_rx_data,
  input  wire logic        rsp_rx_valid,
  input  wire logic        rsp_rx_last,
  input  wire logic        host_rx_active,
  input  wire logic        host_delay_active,
  input  wire logic        host_reply_busy,
  output logic             host_reply_go,
  output logic             exec_possible
);
  import phci_pkg::*;

  logic [7:0]  cmd_buf [`PHCI_BUF_BYTES];
  logic [7:0]  stage   [`PHCI_BUF_BYTES];
  logic [7:0]  rsp_buf [`PHCI_BUF_BYTES];

  logic [2:0]  ctrl_r;
  logic [31:0] counts_r;
  logic [31:0] route_r;
  logic [31:0] retry_cfg_r;
  logic [`PHCI_IRQ_W-1:0] irq_stat_r;
  logic [`PHCI_IRQ_W-1:0] irq_mask_r;
  logic [`PHCI_IRQ_W-1:0] ev_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  phci_state_e state_r;
  phci_cnt_t   idx_r;
  phci_cnt_t   rx_cnt_r;
  phci_cnt_t   rsp_len_r;
  logic [3:0]  tries_r;
  logic [15:0] tenths_r;
  logic [31:0] tick_r;
  logic [7:0]  tx_data_r;
  logic        tx_valid_r;
  logic        tx_last_r;
  logic        exec_r;
  logic        resp_ok_r;

  // Field views
  phci_cnt_t   tx_count;
  phci_cnt_t   rx_count;
  logic [7:0]  dst_net;
  logic [7:0]  dst_node;
  logic [7:0]  dst_unit;
  logic        no_reply;
  logic [3:0]  retries;
  logic [15:0] mon_code;
  assign tx_count = counts_r[9:0];
  assign rx_count = counts_r[25:16];
  assign dst_net  = route_r[7:0];
  assign dst_node = route_r[15:8];
  assign dst_unit = route_r[23:16];
  assign no_reply = route_r[24];  // RULE_08
  assign retries  = retry_cfg_r[3:0];
  assign mon_code = retry_cfg_r[31:16];

  // APB decode
  logic        setup;
  logic        wr_acc;
  logic        in_cmd;
  logic        in_rsp;
  logic [9:0]  base;
  logic [1:0]  win;
  logic        start_req;
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign win    = paddr[11:10];
  assign base   = {paddr[9:2], 2'b00};
  assign in_cmd = (win == `PHCI_WIN_CMD) && (base < 10'(`PHCI_BUF_BYTES));
  assign in_rsp = (win == `PHCI_WIN_RSP) && (base < 10'(`PHCI_BUF_BYTES));
  assign start_req = wr_acc && (paddr == `PHCI_OFS_CTRL) && pwdata[`PHCI_CTRL_START];

  // Control data checks before anything goes on the link
  logic node_max_ok;
  logic params_ok;
  always_comb begin
    node_max_ok = ctrl_r[`PHCI_CTRL_SMALLNET] ? (dst_node <= `PHCI_NODE_MAX_SML)
                                               : (dst_node <= `PHCI_NODE_MAX_BIG);
    params_ok = (dst_net <= `PHCI_NET_MAX)                              // RULE_05
             && node_max_ok                                             // RULE_06
             && (dst_unit >= `PHCI_UNIT_MIN) && (dst_unit <= `PHCI_UNIT_MAX) // RULE_07
             && (tx_count >= `PHCI_CNT_MIN) && (tx_count <= `PHCI_CNT_MAX)   // RULE_01
             && (no_reply || ((rx_count >= `PHCI_CNT_MIN)
                              && (rx_count <= `PHCI_CNT_MAX)));         // RULE_02
  end

  // Duplex ordering gates
  logic full_dpx;
  logic can_start;
  assign full_dpx  = ctrl_r[`PHCI_CTRL_FULLDPX];
  assign can_start = !host_reply_busy                       // RULE_16
                  && !host_delay_active                     // RULE_17
                  && (full_dpx || !host_rx_active);         // RULE_13 RULE_14

  always_comb begin
    if (full_dpx) begin
      // Our command finishes first; the wait for its reply does not block
      host_reply_go = (state_r != ST_SEND)
                   && !((state_r == ST_HOLD) && can_start);  // RULE_15
    end else begin
      // Half duplex holds the reply until the whole exchange is over
      host_reply_go = (state_r == ST_IDLE) && !start_req;    // RULE_13
    end
  end

  // Configuration registers and command buffer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r      <= `PHCI_CTRL_RST;
      counts_r    <= `PHCI_COUNTS_RST;
      route_r     <= `PHCI_ROUTE_RST;
      retry_cfg_r <= `PHCI_RETRY_RST;
      irq_mask_r  <= '0;
    end else if (clk_en && wr_acc) begin
      case (paddr)
        `PHCI_OFS_CTRL:     ctrl_r      <= {pwdata[2:1], 1'b0};
        `PHCI_OFS_IRQ_MASK: irq_mask_r  <= pwdata[`PHCI_IRQ_W-1:0];
        `PHCI_OFS_COUNTS:   counts_r    <= {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
        `PHCI_OFS_ROUTE:    route_r     <= {3'h0, pwdata[28:0]};  // RULE_09 RULE_12
        `PHCI_OFS_RETRY:    retry_cfg_r <= {pwdata[31:16], 12'h000, pwdata[3:0]};
        default: ;
      endcase
    end
  end

  // Buffer is not reset: its contents have no meaning until written
  always_ff @(posedge mclk) begin
    if (clk_en && wr_acc && in_cmd) begin
      for (int b = 0; b < 4; b++) begin
        cmd_buf[base + 10'(b)] <= pwdata[8*b +: 8];
      end
    end
  end

  // Read data registered in the setup phase, answered with no wait state
  logic [31:0] rd_mux;
  logic        rd_err;
  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    if (in_cmd) begin
      for (int b = 0; b < 4; b++) begin
        rd_mux[8*b +: 8] = cmd_buf[base + 10'(b)];
      end
    end else if (in_rsp) begin
      for (int b = 0; b < 4; b++) begin
        rd_mux[8*b +: 8] = rsp_buf[base + 10'(b)];
      end
    end else begin
      case (paddr)
        `PHCI_OFS_CTRL:     rd_mux = {29'h0, ctrl_r};
        `PHCI_OFS_STATUS:   rd_mux = {20'h0, tries_r, 5'h00, resp_ok_r, exec_r,
                                      state_r != ST_IDLE};
        `PHCI_OFS_IRQ_STAT: rd_mux = {28'h0, irq_stat_r};
        `PHCI_OFS_IRQ_MASK: rd_mux = {28'h0, irq_mask_r};
        `PHCI_OFS_COUNTS:   rd_mux = counts_r;
        `PHCI_OFS_ROUTE:    rd_mux = route_r;
        `PHCI_OFS_RETRY:    rd_mux = retry_cfg_r;
        `PHCI_OFS_RSP_LEN:  rd_mux = {22'h0, rsp_len_r};
        default:            rd_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (clk_en && setup) begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= rd_err;
    end
  end

  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign pready  = 1'b1;

  // Sticky events; a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_r <= '0;
    end else if (clk_en) begin
      if (wr_acc && (paddr == `PHCI_OFS_IRQ_STAT)) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[`PHCI_IRQ_W-1:0]) | ev_r;
      end else begin
        irq_stat_r <= irq_stat_r | ev_r;
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Monitor time in clock cycles of one tenth of a second
  logic        tick_end;
  logic [15:0] mon_load;
  assign tick_end = (tick_r == TICK_CYCLES - 1);
  assign mon_load = (mon_code == 16'h0000) ? `PHCI_MON_DEFAULT : mon_code;  // RULE_11

  // Command sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= ST_IDLE;
      idx_r      <= '0;
      rx_cnt_r   <= '0;
      rsp_len_r  <= '0;
      tries_r    <= '0;
      tenths_r   <= '0;
      tick_r     <= '0;
      tx_data_r  <= '0;
      tx_valid_r <= 1'b0;
      tx_last_r  <= 1'b0;
      exec_r     <= 1'b1;
      resp_ok_r  <= 1'b0;
      ev_r       <= '0;
    end else if (clk_en) begin
      ev_r <= '0;
      case (state_r)
        ST_IDLE: begin
          if (start_req) begin
            if (params_ok) begin
              tries_r   <= '0;
              resp_ok_r <= 1'b0;
              exec_r    <= no_reply;  // RULE_18 RULE_19
              state_r   <= ST_HOLD;
            end else begin
              ev_r[`PHCI_IRQ_PARAM] <= 1'b1;
            end
          end
        end
        ST_HOLD: begin
          if (can_start) begin
            idx_r      <= '0;
            tx_data_r  <= cmd_buf[0];
            tx_valid_r <= 1'b1;
            tx_last_r  <= 1'b0;
            state_r    <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (cmd_tx_ready) begin
            if (idx_r == tx_count - 10'd1) begin
              tx_valid_r <= 1'b0;
              tx_last_r  <= 1'b0;
              if (no_reply) begin
                ev_r[`PHCI_IRQ_DONE] <= 1'b1;
                state_r <= ST_IDLE;
              end else begin
                rx_cnt_r <= '0;
                tick_r   <= '0;
                tenths_r <= mon_load;
                state_r  <= ST_WAIT;
              end
            end else begin
              idx_r     <= idx_r + 10'd1;
              tx_data_r <= cmd_buf[idx_r + 10'd1];
              tx_last_r <= (idx_r + 10'd2 == tx_count);
            end
          end
        end
        ST_WAIT: begin
          tick_r <= tick_end ? 32'h0000_0000 : tick_r + 32'h0000_0001;
          if (rsp_rx_valid) begin
            rx_cnt_r <= rx_cnt_r + 10'(rx_cnt_r < 10'(`PHCI_BUF_BYTES));
            if (rsp_rx_last) begin
              if (rx_cnt_r + 10'd1 > rx_count || rx_cnt_r == 10'(`PHCI_BUF_BYTES)) begin
                ev_r[`PHCI_IRQ_DISCARD] <= 1'b1;  // RULE_03
                ev_r[`PHCI_IRQ_DONE]    <= 1'b1;
                exec_r  <= 1'b1;
                state_r <= ST_IDLE;
              end else begin
                rsp_len_r <= rx_cnt_r + 10'd1;
                idx_r     <= '0;
                state_r   <= ST_COPY;
              end
            end
          end else if (tick_end && tenths_r == 16'h0001) begin
            if (tries_r < retries) begin  // RULE_10
              tries_r <= tries_r + 4'h1;
              state_r <= ST_HOLD;
            end else begin
              ev_r[`PHCI_IRQ_TIMEOUT] <= 1'b1;
              ev_r[`PHCI_IRQ_DONE]    <= 1'b1;
              exec_r  <= 1'b1;  // RULE_19
              state_r <= ST_IDLE;
            end
          end else if (tick_end) begin
            tenths_r <= tenths_r - 16'h0001;
          end
        end
        ST_COPY: begin
          // Only the received length is copied, the rest stays as it was
          if (idx_r == rsp_len_r - 10'd1) begin  // RULE_04
            resp_ok_r <= 1'b1;
            exec_r    <= 1'b1;  // RULE_19
            ev_r[`PHCI_IRQ_DONE] <= 1'b1;
            state_r   <= ST_IDLE;
          end else begin
            idx_r <= idx_r + 10'd1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Reply memories stay out of the reset flops; destination sees only fitting replies
  always_ff @(posedge mclk) begin
    if (clk_en && state_r == ST_COPY) begin
      rsp_buf[idx_r] <= stage[idx_r];  // RULE_03 RULE_04
    end
    if (clk_en && state_r == ST_WAIT && rsp_rx_valid && rx_cnt_r < 10'(`PHCI_BUF_BYTES)) begin
      stage[rx_cnt_r] <= rsp_rx_data;
    end
  end

  assign cmd_tx_data   = tx_data_r;
  assign cmd_tx_valid  = tx_valid_r;
  assign cmd_tx_last   = tx_valid_r && (tx_last_r || tx_count == 10'd1);
  assign link_port_sel = route_r[28];  // RULE_12
  assign exec_possible = exec_r;

endmodule // phci_issuer

//--- phci_issuer_monitor.sv
/*
  Port checker of the host command issuer.
  Assumes it is bound to phci_issuer and sees only its ports.
*/
`timescale 1ns/1ps
module phci_issuer_monitor (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  cmd_tx_data,
  input wire logic        cmd_tx_valid,
  input wire logic        cmd_tx_last,
  input wire logic        cmd_tx_ready,
  input wire logic        host_delay_active,
  input wire logic        host_reply_busy,
  input wire logic        host_reply_go,
  input wire logic        exec_possible
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (psel && !penable && clk_en && paddr[11:10] == 2'h3 |=> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (psel && !penable && clk_en && paddr == 12'h004 |=> !pslverr)
    else $error("status access flagged as error");
  a_tx_hold: assert property (cmd_tx_valid && !cmd_tx_ready |=>
    cmd_tx_valid && $stable(cmd_tx_data) && $stable(cmd_tx_last))
    else $error("command byte changed while stalled");
  a_last_valid: assert property (cmd_tx_last |-> cmd_tx_valid)
    else $error("last flag without valid byte");
  a_busy_defers: assert property ($rose(cmd_tx_valid) |-> !$past(host_reply_busy))
    else $error("command started during reply to host");
  a_delay_defers: assert property ($rose(cmd_tx_valid) |-> !$past(host_delay_active))
    else $error("command started inside response delay");
  a_reply_waits: assert property (cmd_tx_valid |-> !host_reply_go)
    else $error("reply granted while command is sent");
  a_exec_cause: assert property ($fell(exec_possible) |->
    $past(psel) && $past(penable) && $past(pwrite)
    && $past(paddr) == 12'h000 && $past(pwdata[0]))
    else $error("execution flag fell without a start");
endmodule // phci_issuer_monitor

bind phci_issuer phci_issuer_monitor u_mon (.*);

//--- phci_issuer_test.sv
/*
  Self-checking bench of the host command issuer over APB.
  Assumes the host model on the link side and a shortened tick.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module phci_issuer_test;
  import phci_pkg::*;
  typedef struct {logic [31:0] ctrl, counts, route; logic bad;} phci_row_s;
  logic        mclk = 0, arst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
  logic        host_rx_active = 0, host_delay_active = 0, host_reply_busy = 0;
  logic        slow = 0, err, pready, pslverr, irq, cmd_tx_valid, cmd_tx_last;
  logic        cmd_tx_ready, link_port_sel, rsp_rx_valid, rsp_rx_last, host_reply_go;
  logic        exec_possible;
  logic [7:0]  cmd_tx_data, rsp_rx_data, last_got, pat = 8'h00;
  logic [7:0]  ex [8];
  int          reply_len = 0, n_got, base, n_errors = 0, tests_run = 0;
  phci_row_s   rows [11];
  int          lens [3] = '{8, 5, 9};
  logic [7:0]  pats [3] = '{8'hA5, 8'h3C, 8'h77};
  logic [2:0]  blk [4] = '{3'b100, 3'b010, 3'b001, 3'b001};

  phci_issuer #(.TICK_CYCLES(4)) dut (.*);
  phci_host_model u_host (.*);

  always #2 mclk = ~mclk;

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, 12'h004, 32'h0000_0000);
      k++;
    end while (rd[0] !== 1'b0 && k < 3000);
    if (k >= 3000) begin
      n_errors++;
      $display("Error busy expected 0 seen 1");
    end
    repeat (2) @(posedge mclk);
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end

  initial begin
    rows = '{'{3, 32'h0002_0002, 32'h0F1F_7E7F, 0}, '{3, 32'h0002_0002, 32'h0110_0080, 1},
      '{3, 32'h0002_0002, 32'h0110_7F00, 1}, '{7, 32'h0002_0002, 32'h0110_3E00, 0},
      '{7, 32'h0002_0002, 32'h0110_3F00, 1}, '{3, 32'h0002_0002, 32'h010F_0000, 1},
      '{3, 32'h0002_0002, 32'h0120_0000, 1}, '{3, 32'h0002_0001, 32'h0110_0000, 1},
      '{3, 32'h0002_021F, 32'h0110_0000, 1}, '{3, 32'h021F_021E, 32'h0110_0000, 0},
      '{3, 32'h021F_0002, 32'h0010_0000, 1}};
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, 12'h000, 0);
    `CHK("ctrl_reset", 32'h0000_0002, rd)
    apb(1'b0, 12'h010, 0);
    `CHK("counts_reset", 32'h0002_0002, rd)
    apb(1'b0, 12'h014, 0);
    `CHK("route_reset", 32'h0010_0000, rd)
    apb(1'b0, 12'hC00, 0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0000_0000, rd)
    apb(1'b1, 12'h400, 32'h4433_2211);
    apb(1'b1, 12'h00C, 32'h0000_0000);
    foreach (rows[i]) begin
      base = n_got;
      apb(1'b1, 12'h010, rows[i].counts);
      apb(1'b1, 12'h014, rows[i].route);
      apb(1'b1, 12'h000, rows[i].ctrl);
      wait_idle();
      apb(1'b0, 12'h008, 0);
      `CHK("param_error", rows[i].bad, rd[3])
      `CHK("bytes_sent", rows[i].bad ? 0 : int'(rows[i].counts[9:0]), n_got - base)
      `CHK("irq_masked", 1'b0, irq)
      apb(1'b1, 12'h008, 32'h0000_000F);
    end
    apb(1'b1, 12'h014, 32'h1110_0000);
    @(posedge mclk);
    `CHK("link_port", 1'b1, link_port_sel)
    apb(1'b1, 12'h010, 32'h0008_0002);
    apb(1'b1, 12'h014, 32'h0110_0000);
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      base = n_got;
      {host_reply_busy, host_delay_active, host_rx_active} <= blk[i];
      apb(1'b1, 12'h000, (i == 2) ? 32'h0000_0001 : 32'h0000_0003);
      repeat (20) @(posedge mclk);
      `CHK("held_off", (i == 3) ? 2 : 0, n_got - base)
      `CHK("reply_go", i != 2, host_reply_go)
      `CHK("exec_flag", 1'b1, exec_possible)
      {host_reply_busy, host_delay_active, host_rx_active} <= 3'b000;
      wait_idle();
      `CHK("sent", 2, n_got - base)
      `CHK("last_byte", 8'h22, last_got)
    end
    slow <= 1'b0;
    apb(1'b1, 12'h014, 32'h0010_0000);
    apb(1'b1, 12'h018, 32'h0010_0000);
    apb(1'b1, 12'h00C, 32'h0000_0001);
    apb(1'b1, 12'h008, 32'h0000_000F);
    for (int j = 0; j < 3; j++) begin
      reply_len <= lens[j];
      pat <= pats[j];
      apb(1'b1, 12'h000, 32'h0000_0003);
      repeat (3) @(posedge mclk);
      `CHK("exec_wait", 1'b0, exec_possible)
      wait_idle();
      `CHK("exec_back", 1'b1, exec_possible)
      `CHK("irq_done", 1'b1, irq)
      apb(1'b0, 12'h008, 0);
      `CHK("discard", j == 2, rd[2])
      apb(1'b1, 12'h008, 32'h0000_000F);
      @(posedge mclk);
      `CHK("irq_clear", 1'b0, irq)
      for (int b = 0; b < 8; b++) begin
        if (b < lens[j] && j < 2) ex[b] = 8'(b) ^ pats[j];
      end
      apb(1'b0, 12'h800, 0);
      `CHK("rsp_word0", {ex[3], ex[2], ex[1], ex[0]}, rd)
      apb(1'b0, 12'h804, 0);
      `CHK("rsp_word1", {ex[7], ex[6], ex[5], ex[4]}, rd)
    end
    reply_len <= 0;
    apb(1'b1, 12'h018, 32'h0001_0002);
    base = n_got;
    apb(1'b1, 12'h000, 32'h0000_0003);
    wait_idle();
    `CHK("tries", 6, n_got - base)
    `CHK("retries_used", 4'h2, rd[11:8])
    apb(1'b0, 12'h008, 0);
    `CHK("timeout", 1'b1, rd[1])
    apb(1'b1, 12'h018, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0003);
    repeat (70) @(posedge mclk);
    apb(1'b0, 12'h004, 0);
    `CHK("default_wait", 1'b1, rd[0])
    wait_idle();
    clk_en <= 1'b0;
    apb(1'b1, 12'h014, 32'h0012_0000);
    clk_en <= 1'b1;
    apb(1'b0, 12'h014, 0);
    `CHK("frozen_write", 32'h0010_0000, rd)
    wrap_up();
  end
endmodule // phci_issuer_test

//--- phci_pkg.sv
/*
  Types of the host command issuer.
  Assumes nothing of its surroundings.
*/
package phci_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_SEND,
    ST_WAIT,
    ST_COPY
  } phci_state_e;
  typedef logic [9:0] phci_cnt_t;
endpackage
